// [hw/mac_slice_params.svh]
// Purpose: offsets, field positions, reset values of the arithmetic slice
// Assumes: included by bare name
// Notes:   definitions only
`ifndef MAC_SLICE_PARAMS_SVH
`define MAC_SLICE_PARAMS_SVH

// ****************************************
// register byte addresses
// ****************************************
`define ADDR_CONFIG      12'h000
`define ADDR_RESULT      12'h004
`define ADDR_STATUS      12'h008

// ****************************************
// configuration field positions
// ****************************************
`define CFG_IN_REG       0
`define CFG_MID_REG      1
`define CFG_OUT_REG      2
`define CFG_SPLIT        3
`define CFG_SIGNED       4
`define CFG_ACC_FB       5
`define CFG_MUL_BYPASS   6
`define CFG_CASCADE      7
`define CFG_WIDTH        8
`define CFG_RESET        8'h07

// ****************************************
// status field positions
// ****************************************
`define STS_CARRY        0
`define STS_SIGN         1

`endif

// [hw/mac_slice_pkg.sv]
// Purpose: shared types of the arithmetic slice
// Assumes: nothing
// Notes:   no constants here, see mac_slice_params.svh
`default_nettype none
package mac_slice_pkg;
   typedef logic [15:0] half_type;
   typedef logic [31:0] word_type;
endpackage
`default_nettype wire

// [hw/mul_core.sv]
// Purpose: one 16x16 multiplier or two 8x8 multipliers
// Assumes: operands settled in the same cycle
// Notes:   purely combinational
`timescale 1ns/1ps
`default_nettype none
module mul_core
(
   input  wire logic                      signed_in,
   input  wire logic                      split_in,
   input  wire mac_slice_pkg::half_type   a_in,
   input  wire mac_slice_pkg::half_type   b_in,
   output mac_slice_pkg::word_type        prod_out
);
   logic signed [16:0] a_full;
   logic signed [16:0] b_full;
   logic signed [33:0] p_full;
   logic signed [8:0]  a_hi;
   logic signed [8:0]  b_hi;
   logic signed [8:0]  a_lo;
   logic signed [8:0]  b_lo;
   logic signed [17:0] p_hi;
   logic signed [17:0] p_lo;

   assign a_full = {a_in[15] & signed_in, a_in};
   assign b_full = {b_in[15] & signed_in, b_in};
   assign a_hi   = {a_in[15] & signed_in, a_in[15:8]};
   assign b_hi   = {b_in[15] & signed_in, b_in[15:8]};
   assign a_lo   = {a_in[7] & signed_in, a_in[7:0]};
   assign b_lo   = {b_in[7] & signed_in, b_in[7:0]};
   assign p_full = a_full * b_full;
   assign p_hi   = a_hi * b_hi;
   assign p_lo   = a_lo * b_lo;
   assign prod_out = split_in ? {p_hi[15:0], p_lo[15:0]} : p_full[31:0];
endmodule
`default_nettype wire

// [hw/addsub_half.sv]
// Purpose: one 16-bit adder/subtracter half
// Assumes: carry in already in raw carry form
// Notes:   sum = y + x or y - x
`timescale 1ns/1ps
`default_nettype none
module addsub_half
(
   input  wire mac_slice_pkg::half_type   x_in,
   input  wire mac_slice_pkg::half_type   y_in,
   input  wire logic                      sub_in,
   input  wire logic                      cin_in,
   output mac_slice_pkg::half_type        sum_out,
   output logic                           cout_out
);
   logic [16:0] total;

   assign total    = {1'b0, y_in} + {1'b0, x_in ^ {16{sub_in}}} + {16'h0000, cin_in};
   assign sum_out  = total[15:0];
   assign cout_out = total[16];
endmodule
`default_nettype wire

// [hw/mac_slice.sv]
// Purpose: multiply-accumulate slice with APB configuration
// Assumes: one clock, all fabric inputs synchronous to clk_in
// Notes:   unused operand inputs are to be tied to zero
//
// Contract
// - one 16x16 multiplier or two independent 8x8 multipliers
// - one 32-bit accumulator or two independent 16-bit accumulators
// - adder/subtracter 32-bit or two 16-bit, result registered or not
// - input, intermediate and output registers each bypassable
// - one clock; common enable gates the operand, product and accumulator registers
// - first and second operands registered, feed multiplier or adder
// - third and fourth operands registered, feed adder; third also preloads the accumulator
// - each operand register has a hold: 1 keeps, 0 updates
// - upper input clear resets first, third operands and upper pipeline
// - lower input clear resets second, fourth operands, lower pipeline, product register
// - output carries 32-bit result or two 16-bit half results
// - each accumulator half has a hold control
// - each accumulator half has its own clear
// - each half loads third operand when preload, else adder result
// - in split mode each half selects add with 0, subtract with 1; otherwise the lower select drives both halves
// - cascade carry in from previous slice, carry out to next
// - carry in from lower fabric tile, carry out to higher tile
// - sign extension in from previous slice, out to next
// - operand inputs have no default value; unused ones must be tied to zero
`timescale 1ns/1ps
`default_nettype none
`include "mac_slice_params.svh"
module mac_slice
(
   input  wire logic                      clk_in,
   input  wire logic                      reset_in,
   // apb slave
   input  wire logic                      psel_in,
   input  wire logic                      penable_in,
   input  wire logic                      pwrite_in,
   input  wire logic [11:0]               paddr_in,
   input  wire logic [31:0]               pwdata_in,
   output logic [31:0]                    prdata_out,
   output logic                           pready_out,
   output logic                           pslverr_out,
   // slice controls
   input  wire logic                      clk_en_in,
   input  wire mac_slice_pkg::half_type   first_operand_in,
   input  wire mac_slice_pkg::half_type   second_operand_in,
   input  wire mac_slice_pkg::half_type   third_operand_in,
   input  wire mac_slice_pkg::half_type   fourth_operand_in,
   input  wire logic                      first_operand_freeze_in,
   input  wire logic                      second_operand_freeze_in,
   input  wire logic                      third_operand_freeze_in,
   input  wire logic                      fourth_operand_freeze_in,
   input  wire logic                      upper_input_clear_in,
   input  wire logic                      lower_input_clear_in,
   input  wire logic                      upper_accum_freeze_in,
   input  wire logic                      upper_accum_clear_in,
   input  wire logic                      upper_accum_preload_in,
   input  wire logic                      upper_subtract_sel_in,
   input  wire logic                      lower_accum_freeze_in,
   input  wire logic                      lower_accum_clear_in,
   input  wire logic                      lower_accum_preload_in,
   input  wire logic                      lower_subtract_sel_in,
   input  wire logic                      chain_carry_in,
   input  wire logic                      tile_carry_in,
   input  wire logic                      chain_sign_in,
   output mac_slice_pkg::word_type        result_out,
   output logic                           chain_carry_out,
   output logic                           tile_carry_out,
   output logic                           chain_sign_out
);

   // ****************************************
   // configuration register
   // ****************************************
   logic [`CFG_WIDTH-1:0]   config_r;
   logic                    in_reg_en;
   logic                    mid_reg_en;
   logic                    out_reg_en;
   logic                    split_mode;
   logic                    signed_mode;
   logic                    acc_feedback;
   logic                    mul_bypass;
   logic                    cascade_mode;

   assign in_reg_en    = config_r[`CFG_IN_REG];
   assign mid_reg_en   = config_r[`CFG_MID_REG];
   assign out_reg_en   = config_r[`CFG_OUT_REG];
   assign split_mode   = config_r[`CFG_SPLIT];
   assign signed_mode  = config_r[`CFG_SIGNED];
   assign acc_feedback = config_r[`CFG_ACC_FB];
   assign mul_bypass   = config_r[`CFG_MUL_BYPASS];
   assign cascade_mode = config_r[`CFG_CASCADE];

   // ****************************************
   // apb slave
   // ****************************************
   logic          setup_phase;
   logic          access_done;
   logic          addr_mapped;
   logic [31:0]   read_value;

   assign setup_phase = psel_in & ~penable_in;
   assign access_done = psel_in & penable_in & pready_out;

   always_comb
   begin
      addr_mapped = 1'b1;
      read_value  = 32'h0000_0000;
      case (paddr_in)
         `ADDR_CONFIG:
         begin
            read_value[`CFG_WIDTH-1:0] = config_r;
         end
         `ADDR_RESULT:
         begin
            read_value = result_out;
         end
         `ADDR_STATUS:
         begin
            read_value[`STS_CARRY] = chain_carry_out;
            read_value[`STS_SIGN]  = chain_sign_out;
         end
         default:
         begin
            addr_mapped = 1'b0;
         end
      endcase
   end

   // one wait-free access cycle after each setup cycle
   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         pready_out  <= 1'b0;
         pslverr_out <= 1'b0;
         prdata_out  <= 32'h0000_0000;
      end
      else
      begin
         pready_out  <= setup_phase;
         pslverr_out <= setup_phase & ~addr_mapped;
         if (setup_phase)
         begin
            prdata_out <= pwrite_in ? 32'h0000_0000 : read_value;
         end
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         config_r <= `CFG_RESET;
      end
      else if (access_done & pwrite_in & (paddr_in == `ADDR_CONFIG))
      begin
         config_r <= pwdata_in[`CFG_WIDTH-1:0];
      end
   end

   // ****************************************
   // operand input registers
   // ****************************************
   // index 0..3 = first..fourth operand
   logic [3:0][15:0]   op_raw;
   logic [3:0][15:0]   op_r;
   logic [3:0][15:0]   op_sel;
   logic [3:0]         op_freeze;
   logic [3:0]         op_clear;

   // ports have no default value; unused ones must be tied to zero
   assign op_raw    = {fourth_operand_in, third_operand_in,
                       second_operand_in, first_operand_in};
   assign op_freeze = {fourth_operand_freeze_in, third_operand_freeze_in,
                       second_operand_freeze_in, first_operand_freeze_in};
   assign op_clear  = {lower_input_clear_in, upper_input_clear_in,
                       lower_input_clear_in, upper_input_clear_in};

   genvar g;
   generate
      for (g = 0; g < 4; g++)
      begin : gen_operand
         always_ff @(posedge clk_in)
         begin
            if (reset_in)
            begin
               op_r[g] <= 16'h0000;
            end
            else if (clk_en_in)
            begin
               if (op_clear[g])
               begin
                  op_r[g] <= 16'h0000;
               end
               else if (!op_freeze[g])
               begin
                  op_r[g] <= op_raw[g];
               end
            end
         end
         assign op_sel[g] = in_reg_en ? op_r[g] : op_raw[g];
      end
   endgenerate

   // ****************************************
   // multiplier and intermediate register
   // ****************************************
   mac_slice_pkg::word_type   prod_w;
   logic [1:0][15:0]          prod_r;
   mac_slice_pkg::word_type   prod_sel;
   logic [1:0]                half_in_clear;

   mul_core u_mul
   (
      .signed_in   (signed_mode),
      .split_in    (split_mode),
      .a_in        (op_sel[0]),
      .b_in        (op_sel[1]),
      .prod_out    (prod_w)
   );

   assign half_in_clear = {upper_input_clear_in | lower_input_clear_in, lower_input_clear_in};

   generate
      for (g = 0; g < 2; g++)
      begin : gen_mid
         always_ff @(posedge clk_in)
         begin
            if (reset_in)
            begin
               prod_r[g] <= 16'h0000;
            end
            else if (clk_en_in)
            begin
               if (half_in_clear[g])
               begin
                  prod_r[g] <= 16'h0000;
               end
               else
               begin
                  prod_r[g] <= prod_w[16*g +: 16];
               end
            end
         end
      end
   endgenerate

   assign prod_sel = mid_reg_en ? prod_r : prod_w;

   // ****************************************
   // adder/subtracter
   // ****************************************
   mac_slice_pkg::word_type   x_word;
   mac_slice_pkg::word_type   y_word;
   logic [1:0][15:0]          acc_r;
   logic [1:0][15:0]          sum_w;
   logic [1:0]                sub_sel;
   logic [1:0]                cin_raw;
   logic [1:0]                cout_raw;
   logic                      ext_carry;

   always_comb
   begin
      if (cascade_mode)
      begin
         x_word = {32{chain_sign_in}};
      end
      else if (mul_bypass)
      begin
         x_word = {op_sel[0], op_sel[1]};
      end
      else
      begin
         x_word = prod_sel;
      end
   end

   assign y_word = acc_feedback ? acc_r : {op_sel[2], op_sel[3]};

   // borrow convention: a set carry in means borrow while subtracting
   assign ext_carry  = cascade_mode ? chain_carry_in : tile_carry_in;
   assign sub_sel[0] = lower_subtract_sel_in;
   assign sub_sel[1] = split_mode ? upper_subtract_sel_in : lower_subtract_sel_in;
   assign cin_raw[0] = ext_carry ^ sub_sel[0];
   assign cin_raw[1] = split_mode ? sub_sel[1] : cout_raw[0];

   generate
      for (g = 0; g < 2; g++)
      begin : gen_adder
         addsub_half u_add
         (
            .x_in      (x_word[16*g +: 16]),
            .y_in      (y_word[16*g +: 16]),
            .sub_in    (sub_sel[g]),
            .cin_in    (cin_raw[g]),
            .sum_out   (sum_w[g]),
            .cout_out  (cout_raw[g])
         );
      end
   endgenerate

   // ****************************************
   // accumulator registers
   // ****************************************
   logic [1:0]         acc_freeze;
   logic [1:0]         acc_clear;
   logic [1:0]         acc_preload;
   logic [1:0][15:0]   acc_nxt;

   assign acc_freeze  = {upper_accum_freeze_in, lower_accum_freeze_in};
   assign acc_clear   = {upper_accum_clear_in, lower_accum_clear_in};
   assign acc_preload = {upper_accum_preload_in, lower_accum_preload_in};

   generate
      for (g = 0; g < 2; g++)
      begin : gen_acc
         assign acc_nxt[g] = acc_preload[g] ? op_sel[2] : sum_w[g];
         always_ff @(posedge clk_in)
         begin
            if (reset_in)
            begin
               acc_r[g] <= 16'h0000;
            end
            else if (clk_en_in)
            begin
               if (acc_clear[g])
               begin
                  acc_r[g] <= 16'h0000;
               end
               else if (!acc_freeze[g])
               begin
                  acc_r[g] <= acc_nxt[g];
               end
            end
         end
      end
   endgenerate

   // ****************************************
   // outputs
   // ****************************************
   logic   carry_ext_out;
   logic   sign_ext_out;

   assign carry_ext_out = cout_raw[1] ^ sub_sel[1];
   assign sign_ext_out  = signed_mode & (y_word[31] ^ x_word[31] ^ sub_sel[1] ^ cout_raw[1]);

   // unregistered mode passes the adder straight out
   always_comb
   begin
      if (out_reg_en)
      begin
         result_out = acc_r;
      end
      else
      begin
         result_out = acc_nxt;
      end
   end

   always_comb
   begin
      chain_carry_out = carry_ext_out;
      tile_carry_out  = carry_ext_out;
      chain_sign_out  = sign_ext_out;
   end

endmodule
`default_nettype wire

// [test/mac_slice_sva.sv]
// Purpose: port checks of the arithmetic slice
// Assumes: configuration followed from apb writes
// Notes:   bound to mac_slice below
`timescale 1ns/1ps
`default_nettype none
module mac_slice_sva
(
   input wire logic                    clk_in,
   input wire logic                    reset_in,
   input wire logic                    psel_in,
   input wire logic                    penable_in,
   input wire logic                    pwrite_in,
   input wire logic [11:0]             paddr_in,
   input wire logic [31:0]             pwdata_in,
   input wire logic [31:0]             prdata_out,
   input wire logic                    pready_out,
   input wire logic                    pslverr_out,
   input wire logic                    clk_en_in,
   input wire logic                    upper_accum_freeze_in,
   input wire logic                    upper_accum_clear_in,
   input wire logic                    lower_accum_freeze_in,
   input wire logic                    lower_accum_clear_in,
   input wire mac_slice_pkg::word_type result_out,
   input wire logic                    chain_carry_out,
   input wire logic                    tile_carry_out,
   input wire logic                    chain_sign_out
);
   logic [7:0] cfg_r;
   logic       cfg_wr;

   assign cfg_wr = psel_in && penable_in && pready_out && pwrite_in && paddr_in == 12'h000;

   // ********
   // configuration shadow
   // ********
   always_ff @(posedge clk_in)
   begin
      if (reset_in)
         cfg_r <= 8'h07;
      else if (cfg_wr)
         cfg_r <= pwdata_in[7:0];
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);

   sequence s_setup;
      psel_in && !penable_in;
   endsequence
   sequence s_access;
      psel_in && penable_in && pready_out;
   endsequence
   sequence s_read(logic [11:0] a);
      psel_in && penable_in && pready_out && !pwrite_in && paddr_in == a;
   endsequence

   chk_ready_next: assert property (s_setup |=> s_access)
      else $error("no ready after setup");
   chk_ready_pulse: assert property (pready_out |-> (psel_in && penable_in) ##1 !pready_out)
      else $error("ready outside one access cycle");
   chk_error_map: assert property (s_access |-> pslverr_out == !(paddr_in inside {12'h000, 12'h004, 12'h008}))
      else $error("error flag wrong for address");
   chk_cfg_read: assert property (s_read(12'h000) |-> prdata_out[7:0] == cfg_r)
      else $error("config read differs");
   chk_status_read: assert property (s_read(12'h008) |-> prdata_out[1] == $past(chain_sign_out)
      && prdata_out[0] == $past(chain_carry_out))
      else $error("status read differs");
   chk_enable_gate: assert property (cfg_r[2] && !clk_en_in && !cfg_wr |=> $stable(result_out))
      else $error("result moved while disabled");
   chk_accum_freeze: assert property (cfg_r[2] && upper_accum_freeze_in && lower_accum_freeze_in
      && !upper_accum_clear_in && !lower_accum_clear_in && !cfg_wr |=> $stable(result_out))
      else $error("result moved while frozen");
   chk_clear_upper: assert property (cfg_r[2] && clk_en_in && upper_accum_clear_in && !cfg_wr
      |=> result_out[31:16] == 16'h0000)
      else $error("upper half not cleared");
   chk_clear_lower: assert property (cfg_r[2] && clk_en_in && lower_accum_clear_in && !cfg_wr
      |=> result_out[15:0] == 16'h0000)
      else $error("lower half not cleared");
   chk_tile_carry: assert property (tile_carry_out == chain_carry_out)
      else $error("carry outputs differ");
   chk_sign_unsigned: assert property (!cfg_r[4] |-> !chain_sign_out)
      else $error("sign out set when unsigned");
endmodule

bind mac_slice mac_slice_sva u_sva
(
   .clk_in(clk_in),
   .reset_in(reset_in),
   .psel_in(psel_in),
   .penable_in(penable_in),
   .pwrite_in(pwrite_in),
   .paddr_in(paddr_in),
   .pwdata_in(pwdata_in),
   .prdata_out(prdata_out),
   .pready_out(pready_out),
   .pslverr_out(pslverr_out),
   .clk_en_in(clk_en_in),
   .upper_accum_freeze_in(upper_accum_freeze_in),
   .upper_accum_clear_in(upper_accum_clear_in),
   .lower_accum_freeze_in(lower_accum_freeze_in),
   .lower_accum_clear_in(lower_accum_clear_in),
   .result_out(result_out),
   .chain_carry_out(chain_carry_out),
   .tile_carry_out(tile_carry_out),
   .chain_sign_out(chain_sign_out)
);
`default_nettype wire

// [test/fabric_neighbour.sv]
// Purpose: previous slice and lower fabric tile feeding the chains
// Assumes: requests come from the bench
// Notes:   levels change just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module fabric_neighbour
(
   input  wire logic clk_in,
   input  wire logic carry_req_in,
   input  wire logic tile_req_in,
   input  wire logic sign_req_in,
   output logic      chain_carry_out,
   output logic      tile_carry_out,
   output logic      chain_sign_out
);
   initial
   begin
      {chain_carry_out, tile_carry_out, chain_sign_out} = 3'h0;
   end
   always @(posedge clk_in)
   begin
      chain_carry_out <= carry_req_in;
      tile_carry_out  <= tile_req_in;
      chain_sign_out  <= sign_req_in;
   end
endmodule
`default_nettype wire

// [test/mac_slice_test.sv]
// Purpose: self-checking bench of the arithmetic slice
// Assumes: zero-wait apb answer, stages as in the hand-over
// Notes:   expectations worked from operand values
`timescale 1ns/1ps
`default_nettype none
module mac_slice_test;
   logic                    clk_in, reset_in, psel_in, penable_in, pwrite_in, clk_en_in, err;
   logic [11:0]             paddr_in;
   logic [31:0]             pwdata_in, prdata_out, rd;
   logic                    pready_out, pslverr_out;
   mac_slice_pkg::half_type opa, opb, opc, opd;
   logic                    fa, fb, fc, fd, uic, lic, uaf, uac, uap, uss, laf, lac, lap, lss;
   logic                    carry_req, tile_req, sign_req, ccar, tcar, csgn, cco, tco, cso;
   mac_slice_pkg::word_type res;
   int                      miscompares, n_checks;

   mac_slice u_dut
   (
      .clk_in(clk_in), .reset_in(reset_in), .psel_in(psel_in), .penable_in(penable_in),
      .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
      .pready_out(pready_out), .pslverr_out(pslverr_out), .clk_en_in(clk_en_in),
      .first_operand_in(opa), .second_operand_in(opb), .third_operand_in(opc), .fourth_operand_in(opd),
      .first_operand_freeze_in(fa), .second_operand_freeze_in(fb), .third_operand_freeze_in(fc),
      .fourth_operand_freeze_in(fd), .upper_input_clear_in(uic), .lower_input_clear_in(lic),
      .upper_accum_freeze_in(uaf), .upper_accum_clear_in(uac), .upper_accum_preload_in(uap),
      .upper_subtract_sel_in(uss), .lower_accum_freeze_in(laf), .lower_accum_clear_in(lac),
      .lower_accum_preload_in(lap), .lower_subtract_sel_in(lss), .chain_carry_in(ccar),
      .tile_carry_in(tcar), .chain_sign_in(csgn), .result_out(res), .chain_carry_out(cco),
      .tile_carry_out(tco), .chain_sign_out(cso)
   );

   fabric_neighbour u_far
   (
      .clk_in(clk_in), .carry_req_in(carry_req), .tile_req_in(tile_req), .sign_req_in(sign_req),
      .chain_carry_out(ccar), .tile_carry_out(tcar), .chain_sign_out(csgn)
   );

   initial
   begin
      clk_in = 1'b0;
      forever #2.5 clk_in = ~clk_in;
   end

   // ********
   // shared tasks
   // ********
   task automatic conclude();
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
      int n;
      psel_in    <= 1'b1;
      penable_in <= 1'b0;
      pwrite_in  <= wr;
      paddr_in   <= addr;
      pwdata_in  <= wd;
      @(posedge clk_in);
      penable_in <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk_in);
         n++;
      end
      while (pready_out !== 1'b1 && n < 20);
      if (n >= 20)
      begin
         miscompares++;
         $display("mismatch pready expected 1 seen timeout");
         conclude();
      end
      rd  = prdata_out;
      err = pslverr_out;
      psel_in    <= 1'b0;
      penable_in <= 1'b0;
      @(posedge clk_in);
   endtask

   task automatic calc(input string what, input logic [63:0] ops, input logic [31:0] exp);
      {opa, opb, opc, opd} <= ops;
      repeat (4) @(posedge clk_in);
      check(what, res, exp);
   endtask

   // ********
   // main sequence
   // ********
   initial
   begin
      {reset_in, clk_en_in, err, rd} = {2'b11, 33'h0};
      {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = '0;
      {opa, opb, opc, opd} = '0;
      {fa, fb, fc, fd, uic, lic, uaf, uac, uap, uss, laf, lac, lap, lss} = '0;
      {carry_req, tile_req, sign_req} = '0;
      miscompares = 0;
      n_checks = 0;
      repeat (4) @(posedge clk_in);
      reset_in <= 1'b0;
      @(posedge clk_in);
      apb(1'b0, 12'h000, 32'h0);
      check("config reset", rd, 32'h0000_0007);
      apb(1'b1, 12'h004, 32'hFFFF_FFFF);
      apb(1'b0, 12'h004, 32'h0);
      check("result read only", rd, 32'h0000_0000);
      apb(1'b0, 12'h00C, 32'h0);
      $display("test registers done");
      calc("full product", 64'h1234_0100_0000_0000, 32'h0012_3400);
      calc("widest product", 64'hFFFF_FFFF_0000_0000, 32'hFFFE_0001);
      {opa, opb} <= 32'h0002_0003;
      repeat (3) @(posedge clk_in);
      check("stage latency", res, 32'hFFFE_0001);
      @(posedge clk_in);
      check("new product", res, 32'h0000_0006);
      calc("operand sum", 64'h0002_0003_0001_FFFF, 32'h0002_0005);
      lss <= 1'b1;
      calc("subtract", 64'h0001_0001_0002_0000, 32'h0001_FFFF);
      lss <= 1'b0;
      calc("overflow", 64'hFFFF_FFFF_FFFF_FFFF, 32'hFFFE_0000);
      check("tile carry out", {31'h0, tco}, 32'h1);
      apb(1'b0, 12'h008, 32'h0);
      check("status carry", {31'h0, rd[0]}, 32'h1);
      tile_req <= 1'b1;
      calc("tile carry in", 64'h0, 32'h0000_0001);
      tile_req <= 1'b0;
      calc("before freeze", 64'h0002_0002_0000_0000, 32'h0000_0004);
      fa <= 1'b1;
      calc("operand freeze", 64'h0007_0002_0000_0000, 32'h0000_0004);
      uic <= 1'b1;
      @(posedge clk_in);
      uic <= 1'b0;
      calc("upper input clear", 64'h0007_0002_0000_0000, 32'h0);
      {fa, fb, lic} <= 3'b011;
      @(posedge clk_in);
      lic <= 1'b0;
      calc("lower input clear", 64'h0007_0002_0000_0000, 32'h0);
      fb <= 1'b0;
      clk_en_in <= 1'b0;
      calc("enable low", 64'h0005_0005_0000_0000, 32'h0);
      clk_en_in <= 1'b1;
      calc("enable high", 64'h0005_0005_0000_0000, 32'h0000_0019);
      $display("test datapath done");
      apb(1'b1, 12'h000, 32'h0000_000F);
      uss <= 1'b1;
      calc("split halves", 64'h0302_0504_0100_FFFF, 32'h00F1_0007);
      uss <= 1'b0;
      apb(1'b1, 12'h000, 32'h0000_0017);
      calc("signed product", 64'hFFFF_0002_0000_0000, 32'hFFFF_FFFE);
      check("sign out", {31'h0, cso}, 32'h1);
      apb(1'b1, 12'h000, 32'h0000_0047);
      calc("multiplier bypass", 64'h0001_0002_0000_0001, 32'h0001_0003);
      apb(1'b1, 12'h000, 32'h0000_0087);
      sign_req <= 1'b1;
      calc("cascade sign", 64'h0000_0000_0000_0005, 32'h0000_0004);
      check("chain carry out", {31'h0, cco}, 32'h1);
      carry_req <= 1'b1;
      calc("cascade carry", 64'h0000_0000_0000_0005, 32'h0000_0005);
      {carry_req, sign_req} <= 2'b00;
      apb(1'b1, 12'h000, 32'h0);
      {opa, opb, opc, opd} <= 64'h0003_0004_0000_0001;
      @(posedge clk_in);
      check("unregistered path", res, 32'h0000_000D);
      $display("test modes done");
      apb(1'b1, 12'h000, 32'h0000_0027);
      {opa, opb, opc, opd} <= 64'h0001_0001_0042_0000;
      {uac, lac, uaf, laf} <= 4'hF;
      repeat (3) @(posedge clk_in);
      {uac, lac} <= 2'b00;
      @(posedge clk_in);
      check("clear beats freeze", res, 32'h0);
      repeat (3) @(posedge clk_in);
      check("accumulator freeze", res, 32'h0);
      apb(1'b0, 12'h004, 32'h0);
      check("result register", rd, 32'h0);
      {uaf, laf} <= 2'b00;
      repeat (5) @(posedge clk_in);
      check("accumulate", res, 32'h0000_0004);
      {uap, lap} <= 2'b11;
      repeat (2) @(posedge clk_in);
      check("preload", res, 32'h0042_0042);
      {uap, lap, uaf} <= 3'b001;
      repeat (4) @(posedge clk_in);
      check("upper freeze only", res, 32'h0042_0045);
      lac <= 1'b1;
      @(posedge clk_in);
      lac <= 1'b0;
      @(posedge clk_in);
      check("lower clear only", res, 32'h0042_0000);
      uaf <= 1'b0;
      $display("test accumulate done");
      conclude();
   end
endmodule
`default_nettype wire
